// File: rtl/sst_pkg.sv
// Purpose: constants and types for the synchronous serial transmit block
// Assumes: 250 MHz system clock, 8-bit register data on a plain port
// Notes: register offsets are byte addresses of aligned words
// Summary of operation
// - transfer active flag at status bit 3
// - shift active flag at status bit 2
// - status address write updates mode control
// - idle run bit 6 keeps block running
// - clock select 111 takes external clock
// - seven internal rates driven on clock pin
// - internal clock pin high at transfer start
// - internal clock pauses until software services
// - transmit on falling, receive on rising edge
// - mode field picks transmit, receive or both
// - load buffer, set go, send LSB first
// - buffer to shifter marks empty, raises interrupt in tx mode
// - internal transmit stalls until buffer written
// - hold previous last bit until first fall
// - clearing go finishes byte then drops active
// - abort stops at once, drops active
// - external go left set sends dummy, stops
// - mode 00 tx, 10 txrx, 11 rx
// - separate write and read data holders
package sst_pkg;
  localparam logic [3:0] ADDR_CTRL1 = 4'h0;
  localparam logic [3:0] ADDR_DATA = 4'h4;
  localparam logic [3:0] ADDR_STAT = 4'h8;
  localparam logic [3:0] ADDR_IDLE = 4'hC;
  localparam int BIT_GO = 7;
  localparam int BIT_ABORT = 6;
  localparam int BIT_XFER_ACT = 3;
  localparam int BIT_SHIFT_ACT = 2;
  localparam int BIT_IDLE_RUN = 6;
  localparam logic [2:0] SCK_EXT = 3'h7;
  localparam logic [1:0] MODE_TX = 2'h0;
  localparam logic [1:0] MODE_TXRX = 2'h2;
  localparam logic [1:0] MODE_RX = 2'h3;
  localparam logic [1:0] MODE_CTRL_RST = 2'h1;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [7:0] BASE_HALF = 8'h02;
  localparam int CLK_PERIOD_NS = 4;
  localparam int EXT_PHASE_MIN_NS = 16;
  localparam int EXT_PHASE_MIN_CYC = (EXT_PHASE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef struct packed {
    logic go;
    logic abort;
    logic [1:0] mode;
    logic [2:0] sck_sel;
  } sst_ctrl1_s;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SHIFT = 2'b01,
    ST_WAIT = 2'b10
  } sst_state_e;
endpackage

// File: rtl/sst_core.sv
// Purpose: clocked synchronous serial transfer engine with its registers
// Assumes: pins are asynchronous to clk_sys_i; idle_i comes from local logic
// Notes: one byte of buffering each way, nothing more
`timescale 1ns/1ps
module sst_core (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  // register port
  input wire logic [3:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  // processor state
  input wire logic idle_i,
  // serial pins
  input wire logic sck_i,
  output logic sck_o,
  output logic sck_oe_o,
  output logic so_o,
  input wire logic si_i,
  // interrupt request, one-cycle pulse
  output logic irq_o
);
  // ***************************************************
  // registers and state
  // ***************************************************
  sst_pkg::sst_ctrl1_s ctrl1;
  sst_pkg::sst_state_e state;
  logic [1:0] mode_ctrl;
  logic idle_run;
  logic idle_b0;
  logic [7:0] tx_buf;
  logic tx_full;
  logic [7:0] rx_buf;
  logic rx_full;
  logic [7:0] tx_sh;
  logic [7:0] rx_sh;
  logic [2:0] bit_cnt;
  logic last_byte;
  logic transfer_active_flag;
  logic [7:0] div_cnt;
  logic sck_q;
  logic sck_m;
  logic sck_s;
  logic sck_d;
  logic si_m;
  logic si_s;

  function automatic logic [7:0] half_period(input logic [2:0] sel);
    half_period = sst_pkg::BASE_HALF << sel;
  endfunction

  // ***************************************************
  // decode
  // ***************************************************
  wire wr_ctrl1 = wr_i && (addr_i == sst_pkg::ADDR_CTRL1);
  wire wr_data = wr_i && (addr_i == sst_pkg::ADDR_DATA);
  wire wr_stat = wr_i && (addr_i == sst_pkg::ADDR_STAT);
  wire wr_idle = wr_i && (addr_i == sst_pkg::ADDR_IDLE);
  wire rd_data = rd_i && (addr_i == sst_pkg::ADDR_DATA);
  wire ext_clk = (ctrl1.sck_sel == sst_pkg::SCK_EXT);
  wire run = !(idle_i && !idle_run);
  wire need_tx = (ctrl1.mode != sst_pkg::MODE_RX);
  wire need_rx = (ctrl1.mode == sst_pkg::MODE_TXRX) || (ctrl1.mode == sst_pkg::MODE_RX);
  wire tx_mode = (ctrl1.mode == sst_pkg::MODE_TX);
  wire serviced = (!need_tx || tx_full) && (!need_rx || !rx_full);
  wire shifting = (state == sst_pkg::ST_SHIFT);
  wire shift_active_flag = shifting;
  wire abort_wr = wr_ctrl1 && wdata_i[sst_pkg::BIT_ABORT];
  wire go_wr = wr_ctrl1 && wdata_i[sst_pkg::BIT_GO] && !abort_wr;
  wire start = go_wr && (state == sst_pkg::ST_IDLE);

  // ***************************************************
  // serial clock edges
  // ***************************************************
  wire tick = run && shifting && !ext_clk && (div_cnt == 8'h00);
  wire int_fall = tick && sck_q;
  wire int_rise = tick && !sck_q;
  wire ext_fall = sck_d && !sck_s;
  wire ext_rise = !sck_d && sck_s;
  wire fall_evt = run && shifting && (ext_clk ? ext_fall : int_fall);
  wire rise_evt = run && shifting && (ext_clk ? ext_rise : int_rise);
  wire byte_done = rise_evt && (bit_cnt == sst_pkg::BIT_LAST);
  wire tx_ready = !need_tx || tx_full;
  wire cont_int = tx_ready && !need_rx;
  wire finish = byte_done && (!ctrl1.go || last_byte);
  wire cont = byte_done && !finish && (ext_clk ? tx_ready : cont_int);
  wire dummy = byte_done && !finish && ext_clk && !tx_ready;
  wire to_wait = byte_done && !finish && !ext_clk && !cont_int;
  wire wait_exit = run && (state == sst_pkg::ST_WAIT) && ctrl1.go && serviced;
  wire begin_shift = (start && run && serviced) || wait_exit || cont;
  wire load = begin_shift && need_tx;
  wire [7:0] rx_next = {si_s, rx_sh[7:1]};

  // status and idle registers read back fixed ones in their reserved bits
  wire [7:0] stat_rd = {4'hF, transfer_active_flag, shift_active_flag, 2'h3};
  wire [7:0] idle_rd = {1'b1, idle_run, 5'h1F, idle_b0};
  wire [7:0] ctrl1_rd = {ctrl1.go, ctrl1.abort, ctrl1.mode, 1'b1, ctrl1.sck_sel};
  wire [7:0] rd_mux = (addr_i == sst_pkg::ADDR_CTRL1) ? ctrl1_rd :
                      (addr_i == sst_pkg::ADDR_DATA) ? rx_buf :
                      (addr_i == sst_pkg::ADDR_STAT) ? stat_rd :
                      (addr_i == sst_pkg::ADDR_IDLE) ? idle_rd : 8'h00;

  // ***************************************************
  // input synchronisers
  // ***************************************************
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sck_m <= 1'b1;
      sck_s <= 1'b1;
      sck_d <= 1'b1;
      si_m <= 1'b0;
      si_s <= 1'b0;
    end else begin
      sck_m <= sck_i;
      sck_s <= sck_m;
      sck_d <= sck_s;
      si_m <= si_i;
      si_s <= si_m;
    end
  end

  // ***************************************************
  // register port
  // ***************************************************
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ctrl1 <= '0;
      mode_ctrl <= sst_pkg::MODE_CTRL_RST;
      idle_run <= 1'b0;
      idle_b0 <= 1'b0;
      rdata_o <= 8'h00;
    end else begin
      if (wr_ctrl1) begin
        // bit 3 always reads one, so it is not stored
        ctrl1 <= {wdata_i[7:4], wdata_i[2:0]};
      end
      if (wr_stat) begin
        mode_ctrl <= wdata_i[3:2];
      end
      if (wr_idle) begin
        idle_run <= wdata_i[sst_pkg::BIT_IDLE_RUN];
        idle_b0 <= wdata_i[0];
      end
      rdata_o <= rd_i ? rd_mux : 8'h00;
    end
  end

  // ***************************************************
  // data holders
  // ***************************************************
  // a write in the same cycle as a load refills the buffer, nothing is lost
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      tx_buf <= 8'h00;
      tx_full <= 1'b0;
      rx_buf <= 8'h00;
      rx_full <= 1'b0;
    end else begin
      if (wr_data) begin
        tx_buf <= wdata_i;
      end
      tx_full <= wr_data || (tx_full && !load);
      if (byte_done && need_rx) begin
        rx_buf <= rx_next;
      end
      rx_full <= (byte_done && need_rx) || (rx_full && !rd_data);
    end
  end

  // ***************************************************
  // internal clock divider
  // ***************************************************
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      div_cnt <= 8'h00;
      sck_q <= 1'b1;
    end else if (!shifting || ext_clk) begin
      div_cnt <= half_period(ctrl1.sck_sel) - 8'h01;
      sck_q <= 1'b1;
    end else if (tick) begin
      div_cnt <= half_period(ctrl1.sck_sel) - 8'h01;
      sck_q <= !sck_q;
    end else if (run) begin
      div_cnt <= div_cnt - 8'h01;
    end
  end

  // ***************************************************
  // transfer control
  // ***************************************************
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state <= sst_pkg::ST_IDLE;
      transfer_active_flag <= 1'b0;
      bit_cnt <= 3'h0;
      last_byte <= 1'b0;
      irq_o <= 1'b0;
    end else begin
      irq_o <= (load && tx_mode) || (byte_done && need_rx);
      if (abort_wr) begin
        state <= sst_pkg::ST_IDLE;
        transfer_active_flag <= 1'b0;
      end else begin
        case (state)
          sst_pkg::ST_IDLE: begin
            if (start) begin
              transfer_active_flag <= 1'b1;
              last_byte <= 1'b0;
              bit_cnt <= 3'h0;
              state <= (run && serviced) ? sst_pkg::ST_SHIFT : sst_pkg::ST_WAIT;
            end
          end
          sst_pkg::ST_SHIFT: begin
            if (rise_evt) begin
              bit_cnt <= bit_cnt + 3'h1;
            end
            if (finish) begin
              state <= sst_pkg::ST_IDLE;
              transfer_active_flag <= 1'b0;
            end else if (to_wait) begin
              state <= sst_pkg::ST_WAIT;
            end else if (dummy) begin
              last_byte <= 1'b1;
            end
          end
          sst_pkg::ST_WAIT: begin
            if (!ctrl1.go) begin
              state <= sst_pkg::ST_IDLE;
              transfer_active_flag <= 1'b0;
            end else if (wait_exit) begin
              state <= sst_pkg::ST_SHIFT;
              bit_cnt <= 3'h0;
            end
          end
          default: begin
            state <= sst_pkg::ST_IDLE;
            transfer_active_flag <= 1'b0;
          end
        endcase
      end
    end
  end

  // ***************************************************
  // shifters and pins
  // ***************************************************
  // serial out moves only on a falling edge, so the previous last bit stays
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      tx_sh <= 8'h00;
      rx_sh <= 8'h00;
      so_o <= 1'b1;
      sck_o <= 1'b1;
      sck_oe_o <= 1'b1;
    end else begin
      if (load) begin
        tx_sh <= tx_buf;
      end else if (fall_evt) begin
        so_o <= tx_sh[0];
        tx_sh <= {1'b1, tx_sh[7:1]};
      end
      if (rise_evt) begin
        rx_sh <= rx_next;
      end
      sck_o <= sck_q;
      sck_oe_o <= !ext_clk;
    end
  end

  // ***************************************************
  // checks
  // ***************************************************
  chk_stat_readback: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    rd_i && (addr_i == sst_pkg::ADDR_STAT) |=> rdata_o[sst_pkg::BIT_XFER_ACT] == $past(transfer_active_flag))
    else $error("status read does not show transfer active");
  chk_shift_in_xfer: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    shift_active_flag |-> transfer_active_flag)
    else $error("shift active without transfer active");
  chk_ext_no_drive: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    ext_clk ##1 ext_clk |-> !sck_oe_o)
    else $error("clock pin driven in external mode");
  chk_sck_high_start: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    $rose(transfer_active_flag) |-> ##1 sck_o)
    else $error("clock pin not high at start");
  chk_wait_clock_still: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    (state == sst_pkg::ST_WAIT) [*3] |-> sck_o && $stable(so_o))
    else $error("clock moved during wait");
  chk_abort_now: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    abort_wr |=> !transfer_active_flag && (state == sst_pkg::ST_IDLE))
    else $error("abort did not stop transfer");
  chk_load_irq: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    load && tx_mode |=> irq_o && (tx_full == $past(wr_data)))
    else $error("load without empty flag and interrupt");
  chk_so_on_fall: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    !$stable(so_o) |-> $past(fall_evt))
    else $error("serial out changed off a falling edge");
  chk_idle_freeze: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    !run && !wr_i |=> $stable(state) && $stable(bit_cnt))
    else $error("block moved while stopped in idle");
  chk_stop_finish: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    finish |=> !transfer_active_flag ##1 !transfer_active_flag)
    else $error("transfer active after finishing");
  cov_tx_byte: cover property (@(posedge clk_sys_i) disable iff (!nrst_i)
    byte_done && tx_mode);
  cov_wait: cover property (@(posedge clk_sys_i) disable iff (!nrst_i)
    to_wait ##[1:400] wait_exit);
  cov_abort: cover property (@(posedge clk_sys_i) disable iff (!nrst_i)
    shifting && abort_wr);
  cov_dummy: cover property (@(posedge clk_sys_i) disable iff (!nrst_i)
    dummy);
endmodule

// File: verif/sst_peer.sv
// Purpose: far-side serial peer, captures the transmit line
// Assumes: bits land LSB first on rising clock edges
// Notes: makes the clock only while run_i is high, stops high
`timescale 1ns/1ps
module sst_peer (
  // pins
  input wire logic sck_i,
  input wire logic so_i,
  output logic sck_o,
  output logic si_o,
  // control and result
  input wire logic run_i,
  input wire logic clr_i,
  output logic [7:0] byte_o,
  output logic done_o
);
  logic [7:0] sh;
  int cnt;
  initial begin
    sck_o = 1'b1;
    si_o = 1'b0;
    done_o = 1'b0;
    byte_o = 8'h00;
    sh = 8'h00;
    cnt = 0;
  end
  // *****
  // clock and capture
  // *****
  // 24 ns phases, far above four system periods
  always begin
    #24;
    if (run_i || !sck_o) begin
      sck_o = !sck_o;
    end
  end
  // changing pattern so a stale sample never matches by luck
  always @(negedge sck_i) begin
    si_o = !si_o;
  end
  always @(posedge sck_i or posedge clr_i) begin
    if (clr_i) begin
      cnt = 0;
    end else begin
      sh = {so_i, sh[7:1]};
      cnt = cnt + 1;
      if (cnt == 8) begin
        cnt = 0;
        byte_o = sh;
        done_o = !done_o;
      end
    end
  end
endmodule

// File: verif/tb_sync_serial_sio_transmit.sv
// Purpose: self-checking bench for the serial transmit block
// Assumes: peer model on the pins, registers on the plain port
// Notes: processor idle input raised once to freeze a running transfer
`timescale 1ns/1ps
module tb_sync_serial_sio_transmit;
  logic clk_sys_i = 1'b0;
  logic nrst_i = 1'b0;
  logic [3:0] addr_i = 4'h0;
  logic [7:0] wdata_i = 8'h00;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic idle_i = 1'b0;
  logic run = 1'b0;
  logic clr = 1'b1;
  logic rd_d = 1'b0;
  logic [7:0] rdata_o, pk_byte, b;
  logic sck_o, sck_oe_o, so_o, si_ln, irq_o, pk_sck, sck_ln, done;
  logic [7:0] rd_q[$];
  logic [7:0] byte_q[$];
  int num_errors = 0;
  int n_compared = 0;
  always #2 clk_sys_i = ~clk_sys_i;
  assign sck_ln = sck_oe_o ? sck_o : pk_sck;
  sst_core DUT (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .idle_i(idle_i),
    .sck_i(sck_ln), .sck_o(sck_o), .sck_oe_o(sck_oe_o), .so_o(so_o), .si_i(si_ln),
    .irq_o(irq_o));
  sst_peer peer (.sck_i(sck_ln), .so_i(so_o), .sck_o(pk_sck), .si_o(si_ln),
    .run_i(run), .clr_i(clr), .byte_o(pk_byte), .done_o(done));
  // *****
  // tasks
  // *****
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] s);
    n_compared++;
    if (s !== e) begin
      num_errors++;
      $display("BAD %s exp %h got %h", nm, e, s);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_sys_i);
    wr_i <= 1'b0;
    @(posedge clk_sys_i);
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    rd_q.push_back(e);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_sys_i);
    rd_i <= 1'b0;
    @(posedge clk_sys_i);
  endtask
  task automatic wait_irq();
    for (int i = 0; i < 400 && irq_o !== 1'b1; i++) @(posedge clk_sys_i);
    chk("irq", 8'h01, {7'h00, irq_o});
  endtask
  task automatic drain();
    for (int i = 0; i < 20000 && byte_q.size() != 0; i++) @(posedge clk_sys_i);
    repeat (40) @(posedge clk_sys_i);
  endtask
  task automatic close_out();
    if (num_errors == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // *****
  // result watchers
  // *****
  always @(posedge clk_sys_i) begin
    if (rd_d) chk("rdata", rd_q.pop_front(), rdata_o);
    rd_d <= rd_i;
  end
  always @(done) if (nrst_i) chk("byte", byte_q.pop_front(), pk_byte);
  initial begin
    #120000;
    num_errors++;
    close_out();
  end
  // *****
  // main sequence
  // *****
  initial begin
    void'($urandom(32'hF553E624));
    repeat (16) @(posedge clk_sys_i);
    nrst_i <= 1'b1;
    clr <= 1'b0;
    @(posedge clk_sys_i);
    rd(4'h8, 8'hF3);
    rd(4'h0, 8'h08);
    rd(4'hC, 8'hBE);
    rd(4'h2, 8'h00);
    wr(4'h4, 8'hA5);
    rd(4'h4, 8'h00);
    wr(4'hC, 8'h40);
    rd(4'hC, 8'hFE);
    wr(4'hC, 8'h00);
    wr(4'h8, 8'h00);
    rd(4'h8, 8'hF3);
    wr(4'h8, 8'h04);
    for (int m = 0; m < 4; m++) if (m != 1) begin
      wr(4'h0, 8'h40 | (m[7:0] << 4));
      rd(4'h0, 8'h48 | (m[7:0] << 4));
    end
    for (int sel = 0; sel < 7; sel++) begin
      wr(4'h0, 8'h40 | sel[7:0]);
      b = 8'($urandom);
      byte_q.push_back(b);
      wr(4'h4, b);
      wr(4'h0, 8'h80 | sel[7:0]);
      wait_irq();
      chk("sck", 8'h01, {7'h00, sck_o});
      chk("oe", 8'h01, {7'h00, sck_oe_o});
      repeat (16 * (2 << sel) + 20) @(posedge clk_sys_i);
      rd(4'h8, 8'hFB);
      chk("sck", 8'h01, {7'h00, sck_o});
      chk("so", {7'h00, b[7]}, {7'h00, so_o});
      b = 8'($urandom);
      byte_q.push_back(b);
      wr(4'h4, b);
      wait_irq();
      wr(4'h0, sel[7:0]);
      drain();
      rd(4'h8, 8'hF3);
    end
    wr(4'h4, 8'($urandom));
    wr(4'h0, 8'h44);
    wr(4'h0, 8'h84);
    repeat (100) @(posedge clk_sys_i);
    rd(4'h8, 8'hFF);
    // idle with idle run off must freeze the byte mid-flight
    idle_i <= 1'b1;
    repeat (200) @(posedge clk_sys_i);
    rd(4'h8, 8'hFF);
    idle_i <= 1'b0;
    wr(4'h0, 8'h42);
    rd(4'h8, 8'hF3);
    clr <= 1'b1;
    @(posedge clk_sys_i);
    clr <= 1'b0;
    b = 8'($urandom);
    byte_q.push_back(b);
    byte_q.push_back(8'hFF);
    wr(4'h0, 8'h47);
    wr(4'h4, b);
    wr(4'h0, 8'h87);
    chk("oe", 8'h00, {7'h00, sck_oe_o});
    run <= 1'b1;
    drain();
    run <= 1'b0;
    repeat (40) @(posedge clk_sys_i);
    rd(4'h8, 8'hF3);
    chk("left", 8'h00, 8'(byte_q.size()));
    close_out();
  end
endmodule
